/* File: rtl/tcr_pkg.sv */
// Package for the capture/reload timer: register map, fields, resets.
// Assumes a 32-bit APB slave with one register per aligned word.
package tcr_pkg;
    // -------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h0C8;
    localparam logic [11:0] ADDR_MODE = 12'h0CC;
    localparam logic [11:0] ADDR_CRL = 12'h0D0;
    localparam logic [11:0] ADDR_CRH = 12'h0D4;
    localparam logic [11:0] ADDR_CNTL = 12'h0D8;
    localparam logic [11:0] ADDR_CNTH = 12'h0DC;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h0E0;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h0E4;
    localparam logic [11:0] ADDR_SER_STAT = 12'h0E8;
    // -------------------------------------------------------------------
    // Control fields
    // -------------------------------------------------------------------
    localparam int CTRL_OVF = 7;
    localparam int CTRL_EXT = 6;
    localparam int CTRL_RXCLK = 5;
    localparam int CTRL_TXCLK = 4;
    localparam int CTRL_TRIG_EN = 3;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_CAP = 0;
    localparam int MODE_UPDN = 0;
    // Interrupt status bits
    localparam int IRQ_OVF = 0;
    localparam int IRQ_EXT = 1;
    localparam int IRQ_CAPT = 2;
    localparam int IRQ_WIDTH = 3;
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;
    // Machine cycle length in core clocks
    localparam int MACHINE_CYCLE_CLKS = 12;
endpackage

/* File: rtl/tcr_timer.sv */
// Third 16-bit timer/counter with capture and auto-reload, APB slave.
// Assumes pins are asynchronous and software uses APB to reach registers.
//
// Summary of operation
// - Overflow sets flag; only software clears it
// - No overflow flag while a serial clock select set
// - Trigger edge capture/reload sets external event flag
// - External event flag requests timer interrupt
// - Up/down mode: external flag raises no interrupt
// - Receive clock select routes overflows to receiver
// - Transmit clock select routes overflows to transmitter
// - Trigger enable allows edge events, else ignored
// - Run bit runs timer, clear holds count except on a trigger edge reload
// - Source select: internal timing or count pin edges
// - Capture mode latches count on trigger edge
// - Reload mode reloads on up-count overflow or, outside up/down mode, trigger edge
// - Serial clocking forces reload on overflow
// - Capture/reload bytes form one 16-bit value
// - Control at 0C8H, resets to zero
// - Trigger pin also direction; count pin counts
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module tcr_timer #(
    parameter int CYCLE_CLKS = tcr_pkg::MACHINE_CYCLE_CLKS
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic COUNT_PIN,
    input wire logic TRIGGER_PIN,
    input wire logic T1_OVERFLOW,
    output logic RX_BAUD_TICK,
    output logic TX_BAUD_TICK,
    output logic TIMER_IRQ,
    output logic IRQ
);
    import tcr_pkg::*;

    if (CYCLE_CLKS < 1 || CYCLE_CLKS > 255) begin : g_bad_cycle_clks
        $error("CYCLE_CLKS out of range");
    end

    // -------------------------------------------------------------------
    // Pin synchronisers and edge detect
    // -------------------------------------------------------------------
    logic [2:0] cnt_sync_r;
    logic [2:0] trg_sync_r;
    logic cnt_level_r;
    logic trg_level_r;
    wire cnt_fall = cnt_level_r & ~cnt_sync_r[2] & ~cnt_sync_r[1];
    wire trg_fall = trg_level_r & ~trg_sync_r[2] & ~trg_sync_r[1];
    wire cnt_rise = ~cnt_level_r & cnt_sync_r[2] & cnt_sync_r[1];
    wire trg_rise = ~trg_level_r & trg_sync_r[2] & trg_sync_r[1];

    always_ff @(posedge CLK_SYS) begin
        cnt_sync_r <= {cnt_sync_r[1:0], COUNT_PIN};
        trg_sync_r <= {trg_sync_r[1:0], TRIGGER_PIN};
        if (!NRST) begin
            cnt_level_r <= 1'b1;
            trg_level_r <= 1'b1;
        end else begin
            if (cnt_fall || cnt_rise) begin
                cnt_level_r <= ~cnt_level_r;
            end
            if (trg_fall || trg_rise) begin
                trg_level_r <= ~trg_level_r;
            end
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] mode_r;
    logic [15:0] cnt_r;
    logic [15:0] cap_r;
    logic [7:0] pre_r;
    logic [IRQ_WIDTH-1:0] ist_r;
    logic [IRQ_WIDTH-1:0] imask_r;

    wire serial_clk = ctrl_r[CTRL_RXCLK] | ctrl_r[CTRL_TXCLK];
    wire up_down = mode_r[MODE_UPDN];

    // Machine cycle prescaler
    wire mc_tick = (pre_r == 8'(CYCLE_CLKS - 1));
    wire [7:0] pre_nxt = mc_tick ? 8'h00 : pre_r + 8'h01;

    // Count enable and direction; trigger pin is direction in up/down
    wire src_tick = ctrl_r[CTRL_SRC] ? cnt_fall : mc_tick;
    wire inc = ctrl_r[CTRL_RUN] & src_tick;
    wire count_down = up_down & ~serial_clk & ~trg_level_r;
    wire ovf_up = inc & ~count_down & (cnt_r == 16'hFFFF);
    wire ovf_dn = inc & count_down & (cnt_r == cap_r);
    wire ovf = ovf_up | ovf_dn;

    // Trigger events, ignored while clocking the serial port
    wire trg_evt = trg_fall & ctrl_r[CTRL_TRIG_EN] & ~serial_clk
                 & ~up_down;
    wire cap_mode = ctrl_r[CTRL_CAP] & ~serial_clk;
    wire do_capture = trg_evt & cap_mode;
    wire do_reload = (ovf_up & ~cap_mode) | (trg_evt & ~cap_mode);

    // -------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------
    wire wr_en = PSEL & PENABLE & PWRITE;
    wire rd_en = PSEL & PENABLE & ~PWRITE;
    wire hit_ctrl = (PADDR == ADDR_CTRL);
    wire hit_mode = (PADDR == ADDR_MODE);
    wire hit_crl = (PADDR == ADDR_CRL);
    wire hit_crh = (PADDR == ADDR_CRH);
    wire hit_cntl = (PADDR == ADDR_CNTL);
    wire hit_cnth = (PADDR == ADDR_CNTH);
    wire hit_ist = (PADDR == ADDR_IRQ_STAT);
    wire hit_imask = (PADDR == ADDR_IRQ_MASK);
    wire hit_ser = (PADDR == ADDR_SER_STAT);
    wire mapped = hit_ctrl | hit_mode | hit_crl | hit_crh | hit_cntl
                | hit_cnth | hit_ist | hit_imask | hit_ser;
    wire [7:0] wbyte = PWDATA[7:0];

    // Read mux
    wire [7:0] rd_byte =
        hit_ctrl ? ctrl_r :
        hit_mode ? mode_r :
        hit_crl ? cap_r[7:0] :
        hit_crh ? cap_r[15:8] :
        hit_cntl ? cnt_r[7:0] :
        hit_cnth ? cnt_r[15:8] :
        hit_ist ? {5'h00, ist_r} :
        hit_imask ? {5'h00, imask_r} :
        hit_ser ? {6'h00, ctrl_r[CTRL_RXCLK], ctrl_r[CTRL_TXCLK]} :
        8'h00;

    // -------------------------------------------------------------------
    // Control register: flags set win over a software write
    // -------------------------------------------------------------------
    wire set_ovf = ovf & ~serial_clk;
    wire set_ext = trg_evt & (do_capture | do_reload);
    wire [7:0] ctrl_wr = (wr_en && hit_ctrl) ? wbyte : ctrl_r;
    wire [7:0] ctrl_nxt = {ctrl_wr[7] | set_ovf,
                           ctrl_wr[6] | set_ext,
                           ctrl_wr[5:0]};

    // Counter next value; software writes lose to hardware activity
    wire [15:0] cnt_step = count_down ? cnt_r - 16'h0001
                                      : cnt_r + 16'h0001;
    wire [15:0] cnt_nxt =
        do_reload ? cap_r :
        ovf_dn ? 16'hFFFF :
        inc ? cnt_step :
        (wr_en && hit_cntl) ? {cnt_r[15:8], wbyte} :
        (wr_en && hit_cnth) ? {wbyte, cnt_r[7:0]} :
        cnt_r;

    wire [15:0] cap_nxt =
        do_capture ? cnt_r :
        (wr_en && hit_crl) ? {cap_r[15:8], wbyte} :
        (wr_en && hit_crh) ? {wbyte, cap_r[7:0]} :
        cap_r;

    wire [IRQ_WIDTH-1:0] ist_evt = {do_capture, set_ext, set_ovf};
    wire [IRQ_WIDTH-1:0] ist_clr = (wr_en && hit_ist) ?
                                   PWDATA[IRQ_WIDTH-1:0] : '0;
    wire [IRQ_WIDTH-1:0] ist_nxt = (ist_r & ~ist_clr) | ist_evt;

    // Timer interrupt request; external flag masked in up/down mode
    wire timer_irq_nxt = ctrl_nxt[CTRL_OVF] |
                         (ctrl_nxt[CTRL_EXT] & ~up_down);

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            ctrl_r <= RST_CTRL;
            mode_r <= RST_MODE;
            cnt_r <= {RST_BYTE, RST_BYTE};
            cap_r <= {RST_BYTE, RST_BYTE};
            pre_r <= 8'h00;
            ist_r <= RST_IRQ;
            imask_r <= RST_IRQ;
        end else begin
            ctrl_r <= ctrl_nxt;
            mode_r <= (wr_en && hit_mode) ? {7'h00, wbyte[0]} : mode_r;
            cnt_r <= cnt_nxt;
            cap_r <= cap_nxt;
            pre_r <= pre_nxt;
            ist_r <= ist_nxt;
            imask_r <= (wr_en && hit_imask) ?
                       PWDATA[IRQ_WIDTH-1:0] : imask_r;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            RX_BAUD_TICK <= 1'b0;
            TX_BAUD_TICK <= 1'b0;
            TIMER_IRQ <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~mapped;
            PRDATA <= (PSEL && !PENABLE && !PWRITE) ?
                      {24'h000000, rd_byte} : PRDATA;
            RX_BAUD_TICK <= ctrl_r[CTRL_RXCLK] ? ovf : T1_OVERFLOW;
            TX_BAUD_TICK <= ctrl_r[CTRL_TXCLK] ? ovf : T1_OVERFLOW;
            TIMER_IRQ <= timer_irq_nxt;
            IRQ <= |(ist_nxt & imask_r);
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_ovf_sets_flag: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        set_ovf |=> ctrl_r[CTRL_OVF])
        else $error("overflow flag not set");
    a_ovf_flag_sticky: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ctrl_r[CTRL_OVF] && !(wr_en && hit_ctrl) |=> ctrl_r[CTRL_OVF])
        else $error("overflow flag cleared by hardware");
    a_no_ovf_serial: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        serial_clk && !ctrl_r[CTRL_OVF] && !(wr_en && hit_ctrl)
        |=> !ctrl_r[CTRL_OVF])
        else $error("overflow flag set while serial clocking");
    a_ext_flag_set: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        trg_evt |=> ctrl_r[CTRL_EXT])
        else $error("external flag not set on trigger");
    a_ext_irq_updn: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        up_down && !ctrl_r[CTRL_OVF] && !set_ovf |=> !TIMER_IRQ
            || ctrl_r[CTRL_OVF])
        else $error("external flag raised irq in up/down mode");
    a_run_hold: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !ctrl_r[CTRL_RUN] && !wr_en && !trg_evt |=> $stable(cnt_r))
        else $error("count moved while stopped");
    a_capture_value: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        do_capture |=> cap_r == $past(cnt_r))
        else $error("capture value wrong");
    a_reload_value: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ovf_up && !cap_mode |=> cnt_r == $past(cap_r))
        else $error("reload on overflow missing");
    a_tx_baud_src: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ctrl_r[CTRL_TXCLK] && ovf |=> TX_BAUD_TICK)
        else $error("transmit baud tick missing");
    a_tx_baud_t1: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !ctrl_r[CTRL_TXCLK] |=> TX_BAUD_TICK == $past(T1_OVERFLOW))
        else $error("transmit tick not from other timer");
    a_rx_baud_src: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ctrl_r[CTRL_RXCLK] && ovf |=> RX_BAUD_TICK)
        else $error("receive baud tick missing");
    a_rx_baud_t1: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !ctrl_r[CTRL_RXCLK] |=> RX_BAUD_TICK == $past(T1_OVERFLOW))
        else $error("receive tick not from other timer");
    a_ext_flag_sticky: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ctrl_r[CTRL_EXT] && !(wr_en && hit_ctrl) |=> ctrl_r[CTRL_EXT])
        else $error("external flag cleared by hardware");
    a_ovf_cleared_sw: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        $fell(ctrl_r[CTRL_OVF]) |-> $past(wr_en && hit_ctrl))
        else $error("overflow flag fell without a write");
    a_ext_cleared_sw: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        $fell(ctrl_r[CTRL_EXT]) |-> $past(wr_en && hit_ctrl))
        else $error("external flag fell without a write");
    a_ext_irq_req: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ctrl_r[CTRL_EXT] && !up_down && !wr_en |=> TIMER_IRQ)
        else $error("external flag raised no request");
    a_ovf_irq_req: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ctrl_r[CTRL_OVF] && !(wr_en && hit_ctrl) |=> TIMER_IRQ)
        else $error("overflow flag raised no request");
    a_trig_ignored: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !ctrl_r[CTRL_TRIG_EN] && !ctrl_r[CTRL_EXT] && !wr_en
        |=> !ctrl_r[CTRL_EXT])
        else $error("trigger edge used while disabled");
    a_src_internal: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !ctrl_r[CTRL_SRC] && !mc_tick && !do_reload && !wr_en
        |=> $stable(cnt_r))
        else $error("count moved off the machine cycle");
    a_src_pin: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ctrl_r[CTRL_SRC] && !cnt_fall && !do_reload && !wr_en
        |=> $stable(cnt_r))
        else $error("count moved without a pin edge");
    a_timer_step: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        inc && !count_down && !do_reload
        |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("count did not step by one");
    a_serial_reload: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        serial_clk && ovf_up |=> cnt_r == $past(cap_r))
        else $error("serial clocking did not reload");
    a_capture_hold: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !do_capture && !(wr_en && (hit_crl || hit_crh))
        |=> $stable(cap_r))
        else $error("capture value moved");
    a_capture_status: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        do_capture |=> ist_r[IRQ_CAPT])
        else $error("capture status not set");
    a_ovf_status: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        set_ovf |=> ist_r[IRQ_OVF])
        else $error("overflow status not set");
    a_ext_status: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        set_ext |=> ist_r[IRQ_EXT])
        else $error("external status not set");
    a_status_sticky: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ist_r[IRQ_OVF] && !(wr_en && hit_ist) |=> ist_r[IRQ_OVF])
        else $error("overflow status lost");
    a_ctrl_write: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        wr_en && hit_ctrl && !set_ovf && !set_ext
        |=> ctrl_r == $past(wbyte))
        else $error("control write not taken");

    // -------------------------------------------------------------------
    // Bus and interrupt line checks
    // -------------------------------------------------------------------
    a_slverr_unmapped: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        PSEL && !PENABLE && !mapped |=> PSLVERR)
        else $error("no error on unmapped address");
    a_slverr_mapped: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        PSEL && !PENABLE && mapped |=> !PSLVERR)
        else $error("error on mapped address");
    a_ready_pulse: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        PSEL && !PENABLE |=> PREADY)
        else $error("ready missing in access phase");
    a_ready_single: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        PREADY |=> !PREADY)
        else $error("ready held past one cycle");
    a_ready_idle: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !PSEL |=> !PREADY)
        else $error("ready without a request");
    a_prdata_hold: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
        else $error("read data moved between reads");
    a_read_upper: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        rd_en |-> PRDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_irq_masked: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        imask_r == '0 && !(wr_en && hit_imask) |=> !IRQ)
        else $error("interrupt with all sources masked");
endmodule // tcr_timer

/* File: test/tcr_pins_model.sv */
// Partner model: drives the count and trigger pins from outside.
// Assumes one core clock; pins idle high as with a pull-up.
`timescale 1ns/1ps
module tcr_pins_model (
    input wire logic clk,
    output logic count_pin,
    output logic trigger_pin
);
    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    initial count_pin = 1'b1;
    initial trigger_pin = 1'b1;
    // Levels held 4 clocks so the synchroniser sees each one
    task automatic count_pulses(input int n);
        repeat (n) begin
            @(posedge clk) count_pin <= 1'b0;
            repeat (4) @(posedge clk);
            count_pin <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic trigger_fall();
        @(posedge clk) trigger_pin <= 1'b0;
        repeat (4) @(posedge clk);
        trigger_pin <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule // tcr_pins_model

/* File: test/timer2_capture_reload_unit_test.sv */
// Testbench: register table, then reload, capture, serial cases.
// Assumes the pin model above and CYCLE_CLKS of 2.
`timescale 1ns/1ps
module timer2_capture_reload_unit_test;
    import tcr_pkg::*;
    typedef struct packed {
        logic wr;
        logic [11:0] a;
        logic [7:0] d;
        logic [7:0] x;
        logic err;
    } tcr_row_type;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, t1 = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, cpin, tpin, rxt, txt, tirq, irq, e;
    int errors = 0, cmp_count = 0, rx_n = 0, tx_n = 0, rx_b, tx_b;
    tcr_row_type rows [11] = '{
        '{1'b0, ADDR_CTRL, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_MODE, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_CRL, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_CRH, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_CNTL, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_CNTH, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_IRQ_STAT, 8'h00, 8'h00, 1'b0},
        '{1'b1, ADDR_CRH, 8'hA5, 8'h00, 1'b0},
        '{1'b0, ADDR_CRH, 8'h00, 8'hA5, 1'b0},
        '{1'b1, ADDR_CTRL, 8'h0A, 8'h00, 1'b0},
        '{1'b0, 12'h0F0, 8'h00, 8'h00, 1'b1}
    };
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (rxt === 1'b1) rx_n <= rx_n + 1;
        if (txt === 1'b1) tx_n <= tx_n + 1;
    end
    tcr_timer #(.CYCLE_CLKS(2)) dut_u (.CLK_SYS(clk), .NRST(nrst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .COUNT_PIN(cpin), .TRIGGER_PIN(tpin),
        .T1_OVERFLOW(t1), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt),
        .TIMER_IRQ(tirq), .IRQ(irq));
    tcr_pins_model pins_u (.clk(clk), .count_pin(cpin),
        .trigger_pin(tpin));
    // ---------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1; pwr <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk) pen <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1 && n < 50);
        if (pready !== 1) begin
            errors++;
            $display("[FAIL] %0t no ready", $time);
        end
        q = prdata;
        e = pslverr;
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        cmp_count++;
        if (got !== x) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, x);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] x);
        apb(0, a, 8'h00);
        chk(q, {24'h0, x});
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (tirq !== 1'b1 && n < 300) begin @(posedge clk); n++; end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(q, {24'h0, rows[i].x});
            chk({31'h0, e}, {31'h0, rows[i].err});
        end
        // Overflow from FFFE reloads FFF0, flag stays until cleared
        apb(1, ADDR_CRL, 8'hF0); apb(1, ADDR_CRH, 8'hFF);
        apb(1, ADDR_CNTL, 8'hFE); apb(1, ADDR_CNTH, 8'hFF);
        apb(1, ADDR_IRQ_MASK, 8'h01);
        apb(1, ADDR_CTRL, 8'h04); wait_irq();
        chk({31'h0, tirq}, 1);
        chk({31'h0, irq}, 1);
        apb(1, ADDR_CTRL, 8'h80);
        rdc(ADDR_CNTH, 8'hFF);
        apb(0, ADDR_CNTL, 8'h00); rdc(ADDR_CNTL, q[7:0]);
        rdc(ADDR_CTRL, 8'h80);
        apb(1, ADDR_CTRL, 8'h00); rdc(ADDR_CTRL, 8'h00);
        chk({31'h0, irq}, 1);
        apb(1, ADDR_IRQ_STAT, 8'h01); chk({31'h0, irq}, 0);
        // Counter mode, capture on trigger edge
        apb(1, ADDR_CNTL, 8'h00); apb(1, ADDR_CNTH, 8'h00);
        apb(1, ADDR_CTRL, 8'h0F);
        pins_u.count_pulses(5); pins_u.trigger_fall();
        rdc(ADDR_CRL, 8'h05); rdc(ADDR_CRH, 8'h00);
        rdc(ADDR_CTRL, 8'h4F); chk({31'h0, tirq}, 1);
        apb(1, ADDR_MODE, 8'h01); repeat (3) @(posedge clk);
        chk({31'h0, tirq}, 0);
        apb(1, ADDR_MODE, 8'h00);
        // Trigger disabled: edge ignored
        apb(1, ADDR_CTRL, 8'h07); pins_u.count_pulses(2);
        pins_u.trigger_fall();
        rdc(ADDR_CRL, 8'h05); rdc(ADDR_CTRL, 8'h07);
        // Serial clocking: forced reload, no flag, ticks routed
        apb(1, ADDR_CRL, 8'hF0); apb(1, ADDR_CRH, 8'hFF);
        apb(1, ADDR_CNTL, 8'hFE); apb(1, ADDR_CNTH, 8'hFF);
        apb(1, ADDR_CTRL, 8'h25); rx_b = rx_n; tx_b = tx_n;
        repeat (3) begin @(posedge clk) t1 <= 1; @(posedge clk) t1 <= 0; end
        repeat (80) @(posedge clk);
        apb(1, ADDR_CTRL, 8'h21);
        rdc(ADDR_CNTH, 8'hFF); rdc(ADDR_CTRL, 8'h21);
        chk({31'h0, rx_n - rx_b > 1}, 1);
        chk(tx_n - tx_b, 3);
        // Transmit side from this timer, receive from the other
        apb(1, ADDR_CTRL, 8'h15); rx_b = rx_n; tx_b = tx_n;
        repeat (2) begin @(posedge clk) t1 <= 1; @(posedge clk) t1 <= 0; end
        repeat (80) @(posedge clk);
        apb(1, ADDR_CTRL, 8'h11);
        chk({31'h0, tx_n - tx_b > 1}, 1);
        chk(rx_n - rx_b, 2);
        rdc(ADDR_CTRL, 8'h11);
        // Reset in mid-run
        nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rdc(ADDR_CTRL, 8'h00);
        rdc(ADDR_CRL, 8'h00);
        chk({31'h0, tirq}, 0);
        give_verdict();
    end
endmodule // timer2_capture_reload_unit_test
